// ==== tws_sram_port.sv ====
// Device side of a two-word burst SRAM with a double-rate shared data bus.
// Assumes the host clocks (k, k_n) are far slower than sys_clk; all pins but sys_clk and rstn are
// brought in through two flip-flops and clock edges are found by sampling.
`timescale 1ns/1ns
`default_nettype none
module tws_sram_port
    import tws_pkg::*;
(
    input  wire logic              sys_clk,
    input  wire logic              rstn,
    input  wire logic              k,
    input  wire logic              k_n,
    input  wire logic              ld_n,
    input  wire logic              rw,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [WORD_W-1:0] dq_in,
    input  wire logic              latency_mode_select,
    output logic      [WORD_W-1:0] dq_out,
    output logic                   dq_oe_n,
    output logic                   read_valid_flag,
    output logic                   output_echo_clock,
    output logic                   output_echo_clock_n
);

    // Storage: one entry per burst, low half is the first word
    logic [BURST_W-1:0] mem [0:DEPTH-1];

    tws_pins_s         pin_raw;
    tws_pins_s         pin_s1;
    tws_pins_s         pin_s2;
    logic              k_prev;
    logic              kn_prev;
    logic              busy;
    logic              pend1;
    logic              pend2;
    logic [ADDR_W-1:0] ra1;
    logic [ADDR_W-1:0] ra2;
    logic              beat2;
    logic [WORD_W-1:0] q_hi;
    tws_wr_e           wr_st;
    tws_wr_e           next_wr_st;
    logic [ADDR_W-1:0] wa;
    logic [WORD_W-1:0] wd0;

    // Pin bundle and its two-stage synchroniser
    assign pin_raw = '{k: k, k_n: k_n, ld_n: ld_n, rw: rw, lat: latency_mode_select,
                       addr: addr, d: dq_in};

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            pin_s1 <= PINS_RST;
            pin_s2 <= PINS_RST;
        end else begin
            pin_s1 <= pin_raw;
            pin_s2 <= pin_s1;
        end
    end

    // Rising edges only; falling edges are never decoded
    wire logic k_rise   = pin_s2.k & ~k_prev;
    wire logic kn_rise  = pin_s2.k_n & ~kn_prev;
    wire logic acc      = k_rise & ~pin_s2.ld_n & ~busy;
    wire logic acc_rd   = acc & pin_s2.rw;
    wire logic acc_wr   = acc & ~pin_s2.rw;
    wire logic launch   = k_rise & (pin_s2.lat ? pend2 : pend1);
    wire logic [ADDR_W-1:0] rsel = pin_s2.lat ? ra2 : ra1;
    wire logic wr_go    = kn_rise & (wr_st == TWS_W_HI);

    // Edge history and address-phase tracking
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            k_prev  <= 1'b0;
            kn_prev <= 1'b0;
            busy    <= 1'b0;
        end else begin
            k_prev  <= pin_s2.k;
            kn_prev <= pin_s2.k_n;
            if (k_rise) begin
                busy <= acc;
            end
        end
    end

    // Read pipeline, advanced on main clock rises
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            pend1 <= 1'b0;
            pend2 <= 1'b0;
            ra1   <= A_RST;
            ra2   <= A_RST;
        end else if (k_rise) begin
            pend1 <= acc_rd;
            pend2 <= pend1;
            ra1   <= pin_s2.addr;
            ra2   <= ra1;
        end
    end

    // Output registers: first word on main rise, second on complement rise
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            dq_out          <= Q_RST;
            q_hi            <= Q_RST;
            dq_oe_n         <= 1'b1;
            read_valid_flag <= 1'b0;
            beat2           <= 1'b0;
        end else if (launch) begin
            {q_hi, dq_out}  <= mem[rsel];
            dq_oe_n         <= 1'b0;
            read_valid_flag <= 1'b1;
            beat2           <= 1'b1;
        end else if (kn_rise && beat2) begin
            dq_out          <= q_hi;
            beat2           <= 1'b0;
        end else if (k_rise) begin
            dq_oe_n         <= 1'b1;
            read_valid_flag <= 1'b0;
        end
    end

    // Echo clocks follow the input clocks through the same register stage
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            output_echo_clock   <= 1'b0;
            output_echo_clock_n <= 1'b0;
        end else begin
            output_echo_clock   <= pin_s2.k;
            output_echo_clock_n <= pin_s2.k_n;
        end
    end

    // Write burst: address edge, word on complement rise, word on main rise
    always_comb begin
        next_wr_st = wr_st;
        case (wr_st)
            TWS_W_IDLE: if (acc_wr) next_wr_st = TWS_W_LO;
            TWS_W_LO:   if (kn_rise) next_wr_st = TWS_W_HI;
            TWS_W_HI:   if (kn_rise) next_wr_st = TWS_W_IDLE;
            default:    next_wr_st = TWS_W_IDLE;
        endcase
    end

    // Word captures; the array is written by itself once both words are in
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            wr_st <= TWS_W_IDLE;
            wa    <= A_RST;
            wd0   <= Q_RST;
        end else begin
            wr_st <= next_wr_st;
            if (acc_wr) begin
                wa <= pin_s2.addr;
            end
            if (wr_st == TWS_W_LO && kn_rise) begin
                wd0 <= pin_s2.d;
            end
        end
    end

    // Second word is taken on the following main rise, then committed
    logic [WORD_W-1:0] wd1;
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            wd1 <= Q_RST;
        end else if (wr_st == TWS_W_HI && k_rise) begin
            wd1 <= pin_s2.d;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (wr_go) begin
            mem[wa] <= {wd1, wd0};
        end
    end

    // Saturating step of a two-bit rise counter
    function automatic logic [1:0] sat_inc(input logic [1:0] v);
        return (v == '1) ? v : v + 2'h1;
    endfunction : sat_inc

    // Checker helpers: main rises seen since the last taken address and the last read
    logic [1:0] rises_since_acc;
    logic [1:0] rises_since_rd;
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            rises_since_acc <= '1;
            rises_since_rd  <= '1;
        end else if (k_rise) begin
            rises_since_acc <= acc ? '0 : sat_inc(rises_since_acc);
            rises_since_rd  <= acc_rd ? '0 : sat_inc(rises_since_rd);
        end
    end

    default clocking dc @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    addr_alternate_a: assert property (acc |-> rises_since_acc != '0)
        else $error("address taken on consecutive main edges");
    wr_commit_a: assert property (wr_go |=> mem[$past(wa)] == {$past(wd1), $past(wd0)})
        else $error("write burst not committed to array");
    rise_only_a: assert property ($changed(dq_out) |-> $past(k_rise || kn_rise))
        else $error("output changed without a rising input edge");
    bus_owner_a: assert property (read_valid_flag == !dq_oe_n)
        else $error("bus drive and valid flag disagree");
    valid_start_a: assert property ($rose(read_valid_flag) |-> $past(launch))
        else $error("valid rose without a launch");
    valid_end_a: assert property ($fell(read_valid_flag) |-> $past(k_rise) && !beat2)
        else $error("valid fell before second beat");
    echo_align_a: assert property ($rose(read_valid_flag) |-> output_echo_clock)
        else $error("read data not aligned with echo clock");
    lat_pick_a: assert property (launch |-> k_rise && rises_since_rd == {1'b0, pin_s2.lat})
        else $error("launch at wrong latency");
    rd_answered_a: assert property (k_rise && rises_since_rd == {1'b0, pin_s2.lat} |-> launch)
        else $error("read address not answered at its latency");
    second_word_a: assert property (kn_rise && beat2 |=> dq_out == $past(q_hi))
        else $error("second read word not launched");

endmodule : tws_sram_port
`default_nettype wire

// ==== tws_pkg.sv ====
// Constants and pin bundle for the two-word burst SRAM port.
// Assumes the narrow configuration: 18-bit words, 4M burst locations.
package tws_pkg;
    localparam int WORD_W  = 18;                 // Data word width
    localparam int ADDR_W  = 22;                 // 4M locations
    localparam int DEPTH   = 4194304;            // Burst locations in the array
    localparam int BURST_W = 2 * WORD_W;         // Two words per location

    localparam logic [WORD_W-1:0]  Q_RST  = 18'h0_0000;
    localparam logic [ADDR_W-1:0]  A_RST  = 22'h00_0000;

    // Write burst progress, one-hot
    typedef enum logic [2:0] {
        TWS_W_IDLE = 3'b001,
        TWS_W_LO   = 3'b010,
        TWS_W_HI   = 3'b100
    } tws_wr_e;

    // Every device pin except sys_clk and rstn, synchronised as one bundle
    typedef struct packed {
        logic              k;
        logic              k_n;
        logic              ld_n;
        logic              rw;
        logic              lat;
        logic [ADDR_W-1:0] addr;
        logic [WORD_W-1:0] d;
    } tws_pins_s;

    localparam tws_pins_s PINS_RST = '{k: 1'b0, k_n: 1'b0, ld_n: 1'b1, rw: 1'b1,
                                       lat: 1'b0, addr: A_RST, d: Q_RST};
endpackage : tws_pkg

// ==== tws_host_model.sv ====
// Host controller model: free-running k/k_n pair and one burst per call.
// Assumes pins may change only at sys_clk falling edges, 8 sys_clk per k.
`timescale 1ns/1ns
`default_nettype none
module tws_host_model
    import tws_pkg::*;
(
    input  wire logic              sys_clk,
    input  wire logic [WORD_W-1:0] dq_out,
    input  wire logic              dq_oe_n,
    input  wire logic              read_valid_flag,
    input  wire logic              output_echo_clock,
    output logic                   k,
    output logic                   k_n,
    output logic                   ld_n,
    output logic                   rw,
    output logic                   lat,
    output logic      [ADDR_W-1:0] addr,
    output logic      [WORD_W-1:0] dq_in
);
    logic [2:0] ph = 3'h0;

    initial begin
        {ld_n, rw, lat, addr, dq_in} = {3'h6, A_RST, Q_RST};
    end

    // Phase counter; k rises at phase 0, k_n at phase 4
    always @(negedge sys_clk) ph <= ph + 3'h1;
    assign k   = (ph < 3'h4);
    assign k_n = ~k;

    // Wait for the falling edge that enters phase p
    task automatic at(input logic [2:0] p);
        do @(posedge sys_clk); while (ph != p - 3'h1);
        @(negedge sys_clk);
    endtask : at

    // One burst; pins change only at quarter points, between clock rises
    task automatic op(input logic r, input logic l, input logic hold,
                      input logic [ADDR_W-1:0] a, inout logic [WORD_W-1:0] w0,
                      inout logic [WORD_W-1:0] w1, output logic [5:0] f);
        f = 6'h00;
        at(3'h6);
        {lat, ld_n, rw, addr} = {l, 1'b0, r, a}; // Address before a k rise
        at(3'h2);
        {ld_n, addr} = {~hold, a ^ 22'h00_0001}; // Held load must be ignored
        if (!r) dq_in = w0; // Word taken at k_n rise
        at(3'h6);
        if (!r) dq_in = w1; // Word taken at k rise
        at(3'h2);
        ld_n = 1'b1;
        if (!r) dq_in = ~w1; // Inverse of w1 driven, no stale value
        if (r) begin
            if (l) at(3'h0);
            at(3'h4);
            w0 = dq_out;
            f[5:3] = {dq_oe_n, read_valid_flag, output_echo_clock};
            at(3'h0);
            w1 = dq_out;
            f[2:1] = {read_valid_flag, output_echo_clock};
            at(3'h4);
            f[0] = read_valid_flag | ~dq_oe_n;
        end
    endtask : op
endmodule : tws_host_model
`default_nettype wire

// ==== testbench.sv ====
// Self-checking bench for the two-word burst SRAM port.
// Assumes the host model owns every pin input except clock and reset.
`timescale 1ns/1ns
`default_nettype none
module testbench;
    import tws_pkg::*;
    logic              sys_clk;
    logic              rstn;
    logic              k, k_n, ld_n, rw, lat, oe_n, vld, echo, echo_n;
    logic [ADDR_W-1:0] addr;
    logic [WORD_W-1:0] dq_in, dq_out;
    int                fail_count  = 0;
    int                check_count = 0;

    tws_host_model host_u (.sys_clk(sys_clk), .dq_out(dq_out), .dq_oe_n(oe_n),
        .read_valid_flag(vld), .output_echo_clock(echo), .k(k), .k_n(k_n),
        .ld_n(ld_n), .rw(rw), .lat(lat), .addr(addr), .dq_in(dq_in));
    tws_sram_port dut_u (.sys_clk(sys_clk), .rstn(rstn), .k(k), .k_n(k_n),
        .ld_n(ld_n), .rw(rw), .addr(addr), .dq_in(dq_in), .latency_mode_select(lat),
        .dq_out(dq_out), .dq_oe_n(oe_n), .read_valid_flag(vld),
        .output_echo_clock(echo), .output_echo_clock_n(echo_n));

    // Clock generator, 40 ns period
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    task automatic check(input logic [WORD_W-1:0] seen, input logic [WORD_W-1:0] exp);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic end_of_test;
        if (fail_count == 0 && check_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : end_of_test

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [WORD_W-1:0] w0,
                      input logic [WORD_W-1:0] w1, input logic hold);
        logic [5:0] f;
        host_u.op(1'b0, 1'b0, hold, a, w0, w1, f);
    endtask : wr

    // Read one burst and judge both words and the flag pattern
    task automatic rd(input logic [ADDR_W-1:0] a, input logic l,
                      input logic [WORD_W-1:0] e0, input logic [WORD_W-1:0] e1);
        logic [WORD_W-1:0] w0, w1;
        logic [5:0]        f;
        host_u.op(1'b1, l, 1'b0, a, w0, w1, f);
        check(w0, e0);
        check(w1, e1);
        check({12'h000, f}, 18'h0_001C);
        check({16'h0000, echo, echo_n}, 18'h0_0002);
    endtask : rd

    // Outputs at their reset values while rstn is held low
    task automatic reset_values;
        check({16'h0000, oe_n, vld}, 18'h0_0002);
        check(dq_out, Q_RST);
        check({16'h0000, echo, echo_n}, 18'h0_0000);
    endtask : reset_values

    // Writes at both address ends, one with an illegal second load
    task automatic bursts_low;
        wr(22'h00_0001, 18'h1_2345, 18'h3_CDEF, 1'b0);
        wr(22'h3F_FFFF, 18'h2_AAAA, 18'h1_5555, 1'b0);
        wr(22'h00_0000, 18'h0_F0F0, 18'h3_0F0F, 1'b1);
        rd(22'h00_0001, 1'b0, 18'h1_2345, 18'h3_CDEF);
        rd(22'h00_0000, 1'b0, 18'h0_F0F0, 18'h3_0F0F);
        rd(22'h3F_FFFF, 1'b0, 18'h2_AAAA, 18'h1_5555);
    endtask : bursts_low

    // Same contents with the longer read latency selected
    task automatic bursts_high;
        rd(22'h3F_FFFF, 1'b1, 18'h2_AAAA, 18'h1_5555);
        rd(22'h00_0000, 1'b1, 18'h0_F0F0, 18'h3_0F0F);
    endtask : bursts_high

    // Main sequence
    initial begin
        rstn = 1'b0;
        repeat (4) @(posedge sys_clk);
        @(negedge sys_clk);
        reset_values();
        rstn = 1'b1;
        bursts_low();
        bursts_high();
        end_of_test();
    end

    // Watchdog far beyond the expected run of about 7.5 us
    initial begin
        #100000;
        fail_count++;
        end_of_test();
    end
endmodule : testbench
`default_nettype wire
